// file: rtl/ssr_pkg.sv
// Package of register map, selector codes and timing constants
package ssr_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PLACE = 8'h00;
  localparam logic [7:0] OFS_IO_SEL1 = 8'h04;
  localparam logic [7:0] OFS_IO_SEL2 = 8'h08;
  localparam logic [7:0] OFS_KP_SEL = 8'h0C;
  localparam logic [7:0] OFS_FB_SEL = 8'h10;
  localparam logic [7:0] OFS_PANEL = 8'h14;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h18;
  localparam logic [7:0] OFS_SPD_SHARE = 8'h1C;
  localparam logic [7:0] OFS_LOAD_SHARE = 8'h20;
  localparam logic [7:0] OFS_JOG = 8'h24;
  localparam logic [7:0] OFS_MPOT_STEP = 8'h28;
  localparam logic [7:0] OFS_PRESET1 = 8'h2C;
  localparam logic [7:0] OFS_PRESET7 = 8'h44;
  localparam logic [7:0] OFS_FREQ_MON = 8'h48;
  localparam logic [7:0] OFS_TORQ_MON = 8'h4C;
  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam int PLACE_W = 2;
  localparam int SHARE_FRAC = 10;
  localparam logic [15:0] SHARE_ONE = 16'h0400;
  localparam logic [15:0] MAX_FREQ_RST = 16'h1388;
  // ----------------------------------------------------------------
  // Control places and selector codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PLACE_IO = 2'h0;
  localparam logic [1:0] PLACE_KEYPAD = 2'h1;
  localparam logic [1:0] PLACE_FBUS = 2'h2;
  localparam logic [4:0] SRC_AI1 = 5'h00;
  localparam logic [4:0] SRC_AI2 = 5'h01;
  localparam logic [4:0] SRC_SUM = 5'h02;
  localparam logic [4:0] SRC_DIFF12 = 5'h03;
  localparam logic [4:0] SRC_DIFF21 = 5'h04;
  localparam logic [4:0] SRC_PROD = 5'h05;
  localparam logic [4:0] SRC_JOY1 = 5'h06;
  localparam logic [4:0] SRC_JOY2 = 5'h07;
  localparam logic [4:0] SRC_PANEL = 5'h08;
  localparam logic [4:0] SRC_FBUS = 5'h09;
  localparam logic [4:0] SRC_MPOT = 5'h0A;
  localparam logic [4:0] SRC_MIN = 5'h0B;
  localparam logic [4:0] SRC_MAX = 5'h0C;
  localparam logic [4:0] SRC_MAXF = 5'h0D;
  localparam logic [4:0] SRC_PICK = 5'h0E;
  localparam logic [4:0] SRC_ENC1 = 5'h0F;
  localparam logic [4:0] SRC_ENC2 = 5'h10;
  localparam logic [4:0] SRC_LAST_IO = 5'h10;
  localparam logic [4:0] SRC_LAST_PANEL = 5'h09;
  // ----------------------------------------------------------------
  // Digital input bit positions
  // ----------------------------------------------------------------
  localparam int DIN_W = 8;
  localparam int DI_TOGGLE = 0;
  localparam int DI_JOG = 1;
  localparam int DI_REV = 2;
  localparam int DI_PRESET0 = 3;
  localparam int DI_UP = 6;
  localparam int DI_DOWN = 7;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int MPOT_TICK_US = 1000;
  localparam int MPOT_TICK_CYC = MPOT_TICK_US * CLK_MHZ;
endpackage

// file: rtl/ssr_speed_ref_sel.sv
// Speed reference selector with overrides, share scaling and APB bank
// Behaviour
// R1: On I/O place, reference source follows the first I/O selector code.
// R2: Code 2 sums inputs, 3 gives one minus two, 4 two minus one.
// R3: Code 5 gives the scaled product of both analogue inputs.
// R4: Codes 6 and 7 pass analogue one or two as signed joystick.
// R5: Code 8 selects the panel value, code 9 the fieldbus reference.
// R6: Code 10 uses a motor potentiometer raised and lowered by inputs.
// R7: Code 11 gives the smaller, code 12 the larger analogue input.
// R8: Code 13 uses the maximum frequency setting as reference.
// R9: Code 14 lets toggle pick input; otherwise toggle picks selector.
// R10: Codes 15 and 16 read encoder one or two; two needs option.
// R11: On keypad place, keypad selector codes 0 to 9 apply.
// R12: On fieldbus place, fieldbus selector codes 0 to 9 apply.
// R13: Second I/O selector has same codes, used when toggle selects it.
// R14: Selected reference scaled by speed share, shown as monitor.
// R15: Torque reference scaled by load share.
// R16: Jog input wins over presets, negated under reverse.
// R17: Three preset inputs form an index; zero keeps basic reference.
// R18: Active preset speed is negated under reverse.
// R19: Without jog or preset the selected reference passes unchanged.
// R20: Undefined selector codes give a zero reference.
`timescale 1ns/1ps
module ssr_speed_ref_sel #(
  parameter int W = 16,
  parameter bit DOUBLE_ENC = 1'b0,
  parameter int MPOT_TICK = ssr_pkg::MPOT_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [W-1:0] analog_in_one,
  input wire logic signed [W-1:0] analog_in_two,
  input wire logic signed [W-1:0] fbus_freq_ref,
  input wire logic signed [W-1:0] enc_one_speed,
  input wire logic signed [W-1:0] enc_two_speed,
  input wire logic signed [W-1:0] torque_ref_in,
  input wire logic [ssr_pkg::DIN_W-1:0] din_pins,
  output logic signed [W-1:0] freq_ref_out,
  output logic signed [W-1:0] torque_ref_out
);
  import ssr_pkg::*;

  localparam int XW = 2 * W + 2;
  localparam logic signed [XW-1:0] HI_LIM = XW'((1 << (W - 1)) - 1);
  localparam logic signed [XW-1:0] LO_LIM = ~HI_LIM;

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [XW-1:0] ext(input logic signed [W-1:0] v);
    ext = {{(W + 2){v[W-1]}}, v};
  endfunction

  // Clamp so that wide sums never wrap round into the opposite sign
  function automatic logic signed [W-1:0] sat(input logic signed [XW-1:0] v);
    if (v > HI_LIM) begin
      sat = HI_LIM[W-1:0];
    end else if (v < LO_LIM) begin
      sat = LO_LIM[W-1:0];
    end else begin
      sat = v[W-1:0];
    end
  endfunction

  // Share is unsigned with SHARE_FRAC fraction bits
  function automatic logic signed [W-1:0] scale(
    input logic signed [W-1:0] v, input logic [15:0] share);
    logic signed [XW-1:0] p;
    p = ext(v) * $signed({{(XW - 16){1'b0}}, share});
    scale = sat(p >>> SHARE_FRAC);
  endfunction

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [PLACE_W-1:0] place_reg;
  logic [SEL_W-1:0] io_sel1_reg;
  logic [SEL_W-1:0] io_sel2_reg;
  logic [SEL_W-1:0] kp_sel_reg;
  logic [SEL_W-1:0] fb_sel_reg;
  logic signed [W-1:0] panel_freq_value_reg;
  logic signed [W-1:0] max_freq_reg;
  logic [15:0] spd_share_reg;
  logic [15:0] load_share_reg;
  logic signed [W-1:0] jog_reg;
  logic signed [W-1:0] mpot_step_reg;
  logic signed [W-1:0] preset_reg [1:7];
  logic signed [W-1:0] mpot_reg;
  logic [31:0] tick_cnt_reg;
  logic [DIN_W-1:0] dsync1_reg;
  logic [DIN_W-1:0] dsync2_reg;
  logic [DIN_W-1:0] dsync3_reg;
  logic [DIN_W-1:0] din_reg;

  // APB decode; one wait state, completion when pready is high
  wire access = psel && penable;
  wire done = access && pready;
  wire wr_en = done && pwrite && mapped; // Refused writes never land
  wire [5:0] widx = paddr[7:2];
  wire is_preset = paddr >= OFS_PRESET1 && paddr <= OFS_PRESET7;
  wire [2:0] pidx = 3'(widx - OFS_PRESET1[7:2] + 6'h01);
  wire mapped = paddr[1:0] == 2'b00 && paddr <= OFS_TORQ_MON;

  // Read selection
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      OFS_PLACE: rd_data = 32'(place_reg);
      OFS_IO_SEL1: rd_data = 32'(io_sel1_reg);
      OFS_IO_SEL2: rd_data = 32'(io_sel2_reg);
      OFS_KP_SEL: rd_data = 32'(kp_sel_reg);
      OFS_FB_SEL: rd_data = 32'(fb_sel_reg);
      OFS_PANEL: rd_data = 32'($unsigned(panel_freq_value_reg));
      OFS_MAX_FREQ: rd_data = 32'($unsigned(max_freq_reg));
      OFS_SPD_SHARE: rd_data = 32'(spd_share_reg);
      OFS_LOAD_SHARE: rd_data = 32'(load_share_reg);
      OFS_JOG: rd_data = 32'($unsigned(jog_reg));
      OFS_MPOT_STEP: rd_data = 32'($unsigned(mpot_step_reg));
      OFS_FREQ_MON: rd_data = 32'($unsigned(freq_ref_out));
      OFS_TORQ_MON: rd_data = 32'($unsigned(torque_ref_out));
      default: begin
        if (is_preset) begin
          rd_data = 32'($unsigned(preset_reg[pidx]));
        end
      end
    endcase
  end

  // Bus answer, registered one cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata <= (access && !pready && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Writes land only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      place_reg <= PLACE_IO;
      io_sel1_reg <= SRC_AI1;
      io_sel2_reg <= SRC_AI2;
      kp_sel_reg <= SRC_PANEL;
      fb_sel_reg <= SRC_FBUS;
      panel_freq_value_reg <= '0;
      max_freq_reg <= W'(MAX_FREQ_RST);
      spd_share_reg <= SHARE_ONE;
      load_share_reg <= SHARE_ONE;
      jog_reg <= '0;
      mpot_step_reg <= '0;
      for (int i = 1; i <= 7; i++) begin
        preset_reg[i] <= '0;
      end
    end else if (wr_en) begin
      case (paddr)
        OFS_PLACE: place_reg <= pwdata[PLACE_W-1:0];
        OFS_IO_SEL1: io_sel1_reg <= pwdata[SEL_W-1:0];
        OFS_IO_SEL2: io_sel2_reg <= pwdata[SEL_W-1:0];
        OFS_KP_SEL: kp_sel_reg <= pwdata[SEL_W-1:0];
        OFS_FB_SEL: fb_sel_reg <= pwdata[SEL_W-1:0];
        OFS_PANEL: panel_freq_value_reg <= pwdata[W-1:0];
        OFS_MAX_FREQ: max_freq_reg <= pwdata[W-1:0];
        OFS_SPD_SHARE: spd_share_reg <= pwdata[15:0];
        OFS_LOAD_SHARE: load_share_reg <= pwdata[15:0];
        OFS_JOG: jog_reg <= pwdata[W-1:0];
        OFS_MPOT_STEP: mpot_step_reg <= pwdata[W-1:0];
        default: begin
          if (is_preset) begin
            preset_reg[pidx] <= pwdata[W-1:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Digital input conditioning
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsync1_reg <= '0;
      dsync2_reg <= '0;
      dsync3_reg <= '0;
      din_reg <= '0;
    end else begin
      dsync1_reg <= din_pins;
      dsync2_reg <= dsync1_reg;
      dsync3_reg <= dsync2_reg;
      din_reg <= (dsync2_reg == dsync3_reg) ? dsync3_reg : din_reg;
    end
  end

  wire toggle = din_reg[DI_TOGGLE];
  wire jog = din_reg[DI_JOG];
  wire rev = din_reg[DI_REV];
  wire [2:0] preset_idx = din_reg[DI_PRESET0 +: 3];
  wire up = din_reg[DI_UP];
  wire down = din_reg[DI_DOWN];

  // ----------------------------------------------------------------
  // Motor potentiometer
  // ----------------------------------------------------------------
  // R6: up/down ramp
  // Steps at a fixed tick, clamped to the frequency limit both ways
  wire tick = tick_cnt_reg == 32'(MPOT_TICK - 1);
  wire signed [XW-1:0] mpot_up = ext(mpot_reg) + ext(mpot_step_reg);
  wire signed [XW-1:0] mpot_dn = ext(mpot_reg) - ext(mpot_step_reg);
  wire signed [W-1:0] mpot_next =
    (up && !down) ? (mpot_up > ext(max_freq_reg) ? max_freq_reg :
                     mpot_up[W-1:0]) :
    (down && !up) ? (mpot_dn < -ext(max_freq_reg) ? W'(-max_freq_reg) :
                     mpot_dn[W-1:0]) : mpot_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      mpot_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      mpot_reg <= tick ? mpot_next : mpot_reg;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // R13: toggle picks the second selector
  // R9: code 14 keeps toggle for the input pick instead
  wire [SEL_W-1:0] io_code =
    (toggle && io_sel1_reg != SRC_PICK) ? io_sel2_reg : io_sel1_reg;
  // R1: I/O place codes
  // R11: keypad place codes
  // R12: fieldbus place codes
  wire [SEL_W-1:0] act_code = place_reg == PLACE_IO ? io_code :
    place_reg == PLACE_KEYPAD ? kp_sel_reg : fb_sel_reg;
  // R20: undefined codes or places give zero
  wire code_ok = place_reg == PLACE_IO ? act_code <= SRC_LAST_IO :
    place_reg == PLACE_KEYPAD || place_reg == PLACE_FBUS ?
    act_code <= SRC_LAST_PANEL : 1'b0;

  // R2: combined analogue terms, saturated
  wire signed [W-1:0] ai_sum = sat(ext(analog_in_one) + ext(analog_in_two));
  wire signed [W-1:0] ai_d12 = sat(ext(analog_in_one) - ext(analog_in_two));
  wire signed [W-1:0] ai_d21 = sat(ext(analog_in_two) - ext(analog_in_one));
  // R3: product in full-scale fraction, so 100 % x 100 % is 100 %
  wire signed [W-1:0] ai_prod =
    sat((ext(analog_in_one) * ext(analog_in_two)) >>> (W - 1));
  // R7: smaller and larger input
  wire one_lt = analog_in_one < analog_in_two;
  wire signed [W-1:0] ai_min = one_lt ? analog_in_one : analog_in_two;
  wire signed [W-1:0] ai_max = one_lt ? analog_in_two : analog_in_one;

  logic signed [W-1:0] base_ref;
  always_comb begin
    base_ref = '0;
    case (act_code)
      SRC_AI1: base_ref = analog_in_one;
      SRC_AI2: base_ref = analog_in_two;
      SRC_SUM: base_ref = ai_sum;
      SRC_DIFF12: base_ref = ai_d12;
      SRC_DIFF21: base_ref = ai_d21;
      SRC_PROD: base_ref = ai_prod;
      // R4: joystick inputs keep their sign
      SRC_JOY1: base_ref = analog_in_one;
      SRC_JOY2: base_ref = analog_in_two;
      // R5: panel and fieldbus values
      SRC_PANEL: base_ref = panel_freq_value_reg;
      SRC_FBUS: base_ref = fbus_freq_ref;
      SRC_MPOT: base_ref = mpot_reg;
      SRC_MIN: base_ref = ai_min;
      SRC_MAX: base_ref = ai_max;
      // R8: limit used as reference
      SRC_MAXF: base_ref = max_freq_reg;
      SRC_PICK: base_ref = toggle ? analog_in_two : analog_in_one;
      // R10: second encoder only with the option fitted
      SRC_ENC1: base_ref = enc_one_speed;
      SRC_ENC2: base_ref = DOUBLE_ENC ? enc_two_speed : '0;
      default: base_ref = '0;
    endcase
    if (!code_ok) begin
      base_ref = '0;
    end
  end

  // ----------------------------------------------------------------
  // Overrides and share scaling
  // ----------------------------------------------------------------
  // R16: jog first, direction follows reverse
  // R17: preset index picks a stored speed
  // R18: preset sign follows reverse
  // R19: otherwise the basic reference passes unchanged
  wire signed [W-1:0] const_ref = jog ? jog_reg : preset_reg[preset_idx];
  wire signed [W-1:0] const_dir = rev ? sat(-ext(const_ref)) : const_ref;
  wire signed [W-1:0] over_ref =
    (jog || preset_idx != 3'h0) ? const_dir : base_ref;

  // Registered so the monitor and outputs never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_ref_out <= '0;
      torque_ref_out <= '0;
    end else begin
      // R14: speed share on the jog, preset or selected reference
      freq_ref_out <= scale(over_ref, spd_share_reg);
      // R15: load share on torque
      torque_ref_out <= scale(torque_ref_in, load_share_reg);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire plain_io = place_reg == PLACE_IO && !toggle && !jog &&
    preset_idx == 3'h0 && spd_share_reg == SHARE_ONE;

  a_io_first_sel: assert property (@(posedge pclk) disable iff (!presetn)
    plain_io && io_sel1_reg == SRC_AI1 |=> // R1
    freq_ref_out == $past(analog_in_one))
    else $error("io place does not follow first selector");

  a_diff_path: assert property (@(posedge pclk) disable iff (!presetn)
    plain_io && io_sel1_reg == SRC_DIFF12 |=> // R2
    freq_ref_out == $past(ai_d12))
    else $error("difference source wrong");

  a_min_path: assert property (@(posedge pclk) disable iff (!presetn)
    plain_io && io_sel1_reg == SRC_MIN |=> // R7
    freq_ref_out <= $past(analog_in_one) &&
    freq_ref_out <= $past(analog_in_two) &&
    (freq_ref_out == $past(analog_in_one) ||
    freq_ref_out == $past(analog_in_two)))
    else $error("minimum source not smaller");

  a_max_freq_src: assert property (@(posedge pclk) disable iff (!presetn)
    plain_io && io_sel1_reg == SRC_MAXF |=> // R8
    freq_ref_out == $past(max_freq_reg))
    else $error("max frequency source wrong");

  a_panel_range: assert property (@(posedge pclk) disable iff (!presetn)
    place_reg == PLACE_KEYPAD && kp_sel_reg > SRC_LAST_PANEL && // R20
    !jog && preset_idx == 3'h0 |=> freq_ref_out == '0)
    else $error("undefined keypad code not zero");

  a_jog_reverse: assert property (@(posedge pclk) disable iff (!presetn)
    jog && rev && spd_share_reg == SHARE_ONE |=> // R16
    freq_ref_out == $past(sat(-ext(jog_reg))))
    else $error("jog not negated under reverse");

  a_preset_pick: assert property (@(posedge pclk) disable iff (!presetn)
    !jog && !rev && preset_idx != 3'h0 && // R17
    spd_share_reg == SHARE_ONE |=> freq_ref_out == $past(const_ref))
    else $error("preset index wrong");

  a_load_share: assert property (@(posedge pclk) disable iff (!presetn)
    load_share_reg == SHARE_ONE |=> // R15
    torque_ref_out == $past(torque_ref_in))
    else $error("unity load share changed torque");

  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  c_jog: cover property (@(posedge pclk) disable iff (!presetn)
    jog && rev);
  c_preset7: cover property (@(posedge pclk) disable iff (!presetn)
    !jog && preset_idx == 3'h7);
  c_mpot_move: cover property (@(posedge pclk) disable iff (!presetn)
    tick && up && !down);
  c_bus_error: cover property (@(posedge pclk) disable iff (!presetn)
    done && pslverr);
endmodule

// file: sim/ssr_far_side.sv
// Far-side model: analogue, fieldbus, encoder and pin sources
`timescale 1ns/1ps
module ssr_far_side (
  input wire logic pclk,
  input wire logic signed [15:0] a1_w,
  input wire logic signed [15:0] a2_w,
  input wire logic signed [15:0] fb_w,
  input wire logic signed [15:0] e1_w,
  input wire logic signed [15:0] e2_w,
  input wire logic signed [15:0] tq_w,
  input wire logic [2:0] pidx_w,
  input wire logic [4:0] sw_w,
  output logic signed [15:0] analog_in_one = 16'h0000,
  output logic signed [15:0] analog_in_two = 16'h0000,
  output logic signed [15:0] fbus_freq_ref = 16'h0000,
  output logic signed [15:0] enc_one_speed = 16'h0000,
  output logic signed [15:0] enc_two_speed = 16'h0000,
  output logic signed [15:0] torque_ref_in = 16'h0000,
  output logic [7:0] din_pins = 8'h00
);
  import ssr_pkg::*;
  // ----------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------
  // Switches: 0 toggle, 1 jog, 2 reverse, 3 up, 4 down
  always @(posedge pclk) begin
    analog_in_one <= a1_w;
    analog_in_two <= a2_w;
    fbus_freq_ref <= fb_w;
    enc_one_speed <= e1_w;
    enc_two_speed <= e2_w;
    torque_ref_in <= tq_w;
    din_pins[DI_TOGGLE] <= sw_w[0];
    din_pins[DI_JOG] <= sw_w[1];
    din_pins[DI_REV] <= sw_w[2];
    din_pins[DI_PRESET0 +: 3] <= pidx_w;
    din_pins[DI_UP] <= sw_w[3];
    din_pins[DI_DOWN] <= sw_w[4];
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the speed reference selector
`timescale 1ns/1ps
module testbench;
  import ssr_pkg::*;
  typedef struct {logic [32:0] v; logic [31:0] m; string n;} ssr_note_type;
  localparam logic [15:0] PANEL_V = 16'h0123;
  localparam logic [31:0] RST_V [9] = '{32'h0000_0000, 32'h0000_0000,
    32'h0000_0001, 32'h0000_0008, 32'h0000_0009, 32'h0000_0000,
    32'h0000_1388, 32'h0000_0400, 32'h0000_0400};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic signed [15:0] ai1 = '0, ai2 = '0, fbv = '0, enc1 = '0;
  logic signed [15:0] enc2 = '0, trq = '0;
  logic tog = 1'b0, jog = 1'b0, rev = 1'b0, up = 1'b0, dn = 1'b0;
  logic [2:0] pidx = 3'h0;
  logic signed [15:0] a1_i, a2_i, fb_i, e1_i, e2_i, tq_i, f_o, t_o;
  logic [7:0] din;
  int seed = 40567;
  int fails = 0;
  int checks_done = 0;
  longint sshare = 1024;
  ssr_note_type notes[$];
  ssr_note_type note;

  always #2.5 pclk = ~pclk;

  ssr_far_side i_far (.pclk(pclk), .a1_w(ai1), .a2_w(ai2), .fb_w(fbv),
    .e1_w(enc1), .e2_w(enc2), .tq_w(trq), .pidx_w(pidx),
    .sw_w({dn, up, rev, jog, tog}), .analog_in_one(a1_i),
    .analog_in_two(a2_i), .fbus_freq_ref(fb_i), .enc_one_speed(e1_i),
    .enc_two_speed(e2_i), .torque_ref_in(tq_i), .din_pins(din));
  ssr_speed_ref_sel #(.W(16), .DOUBLE_ENC(1'b0), .MPOT_TICK(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_in_one(a1_i),
    .analog_in_two(a2_i), .fbus_freq_ref(fb_i), .enc_one_speed(e1_i),
    .enc_two_speed(e2_i), .torque_ref_in(tq_i), .din_pins(din),
    .freq_ref_out(f_o), .torque_ref_out(t_o));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic longint sat(input longint x);
    return (x > 32767) ? 32767 : (x < -32768) ? -32768 : x;
  endfunction
  function automatic logic [15:0] scl(input longint v, input longint s);
    longint p;
    p = sat((v * s) >>> 10);
    return p[15:0];
  endfunction
  // Codes above the place's limit hold zero, as do mpot idle and enc two
  function automatic longint src(input int c, input int lim);
    longint a, b;
    a = ai1;
    b = ai2;
    if (c > lim) return 0;
    case (c)
      0, 6: return a;
      1, 7: return b;
      2: return sat(a + b);
      3: return sat(a - b);
      4: return sat(b - a);
      5: return sat((a * b) >>> 15);
      8: return PANEL_V;
      9: return fbv;
      11: return (a < b) ? a : b;
      12: return (a > b) ? a : b;
      13: return MAX_FREQ_RST;
      14: return tog ? b : a;
      15: return enc1;
      default: return 0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [7:0] a,
                     input logic [32:0] v, input logic [31:0] m);
    ssr_note_type t;
    t.v = v;
    t.m = m;
    t.n = n;
    notes.push_back(t);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // Pins pass the filter in about six edges, so eight is a safe settle
  task automatic fchk(input string n, input longint e);
    repeat (8) @(posedge pclk);
    checks_done++;
    if (f_o !== scl(e, sshare)) begin
      fails++;
      $display("BAD freq_ref_out exp %h got %h", scl(e, sshare), f_o);
    end
    chk(n, OFS_FREQ_MON, {17'h0_0000, scl(e, sshare)}, 32'h0000_ffff);
  endtask
  task automatic rnd;
    int r;
    r = $random(seed);
    ai1 <= r[15:0];
    ai2 <= r[31:16];
    r = $random(seed);
    fbv <= r[15:0];
    enc1 <= r[31:16];
    r = $random(seed);
    enc2 <= r[15:0];
    trq <= r[31:16];
    @(posedge pclk);
  endtask
  task automatic pins(input logic t, j, r, input logic [2:0] p);
    tog <= t;
    jog <= j;
    rev <= r;
    pidx <= p;
    @(posedge pclk);
  endtask
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Scoreboard: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
    begin
      note = notes.pop_front();
      checks_done++;
      if ({pslverr, prdata & note.m} !== note.v) begin
        fails++;
        $display("BAD %s exp %h got %h", note.n, note.v,
                 {pslverr, prdata & note.m});
      end
    end
  end

  // Watchdog: normal run is under two thousand cycles
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
      chk("reset_val", 8'(i * 4), {1'b0, RST_V[i]}, 32'hffff_ffff);
    chk("unmapped", 8'h50, {1'b1, 32'h0000_0000}, 32'hffff_ffff);
    chk("misaligned", 8'h06, {1'b1, 32'h0000_0000}, 32'hffff_ffff);
    apb(1'b1, OFS_PANEL, {16'h0000, PANEL_V});
    for (int c = 0; c < 18; c++) begin
      rnd();
      apb(1'b1, OFS_IO_SEL1, 32'(c));
      fchk("io_code", src(c, 16));
    end
    // Toggle picks the second selector, or the second input on code 14
    pins(1'b1, 1'b0, 1'b0, 3'h0);
    apb(1'b1, OFS_IO_SEL1, 32'h0000_0003);
    apb(1'b1, OFS_IO_SEL2, 32'h0000_000c);
    fchk("io_sel2", src(12, 16));
    apb(1'b1, OFS_IO_SEL1, 32'h0000_000e);
    fchk("ai_pick", src(14, 16));
    pins(1'b0, 1'b0, 1'b0, 3'h0);
    // Keypad, fieldbus and the unused place
    for (int p = 1; p < 4; p++) begin
      rnd();
      for (int c = 0; c < 11; c++) begin
        apb(1'b1, OFS_PLACE, 32'(p));
        apb(1'b1, (p == 1) ? OFS_KP_SEL : OFS_FB_SEL, 32'(c));
        fchk("place_code", (p == 3) ? 0 : src(c, 9));
      end
    end
    // Presets and jog over the basic reference
    apb(1'b1, OFS_PLACE, 32'h0000_0000);
    apb(1'b1, OFS_IO_SEL1, 32'h0000_0000);
    apb(1'b1, OFS_JOG, 32'h0000_0200);
    for (int i = 1; i < 8; i++)
      apb(1'b1, 8'(OFS_PRESET1 + 4 * (i - 1)), 32'(i * 64));
    // Misaligned write inside the preset range must not land
    apb(1'b1, 8'h2e, 32'h0000_7777);
    chk("bad_write", OFS_PRESET1, {1'b0, 32'h0000_0040},
        32'hffff_ffff);
    for (int i = 0; i < 16; i++) begin
      pins(1'b0, 1'b0, i[0], i[3:1]);
      fchk("preset", (i < 2) ? src(0, 16) :
           (i[0] ? -(i / 2) * 64 : (i / 2) * 64));
    end
    pins(1'b0, 1'b1, 1'b1, 3'h5);
    fchk("jog_rev", -512);
    pins(1'b0, 1'b1, 1'b0, 3'h5);
    fchk("jog_fwd", 512);
    pins(1'b0, 1'b0, 1'b0, 3'h0);
    // Motor pot steps and clamps at the frequency limit
    apb(1'b1, OFS_MAX_FREQ, 32'h0000_0064);
    apb(1'b1, OFS_MPOT_STEP, 32'h0000_0030);
    apb(1'b1, OFS_IO_SEL1, 32'h0000_000a);
    up <= 1'b1;
    repeat (80) @(posedge pclk);
    up <= 1'b0;
    fchk("mpot_up", 100);
    dn <= 1'b1;
    repeat (200) @(posedge pclk);
    dn <= 1'b0;
    fchk("mpot_down", -100);
    apb(1'b1, OFS_IO_SEL1, 32'h0000_000d);
    fchk("max_freq", 100);
    // Share scaling; monitor write must be ignored
    apb(1'b1, OFS_IO_SEL1, 32'h0000_0000);
    apb(1'b1, OFS_SPD_SHARE, 32'h0000_0200);
    apb(1'b1, OFS_LOAD_SHARE, 32'h0000_0600);
    apb(1'b1, OFS_FREQ_MON, 32'h0000_5555);
    sshare = 512;
    rnd();
    fchk("speed_share", src(0, 16));
    chk("load_share", OFS_TORQ_MON, {17'h0_0000, scl(trq, 1536)},
        32'h0000_ffff);
    wrap_up();
  end
endmodule
